// [verilog/lcds_select_low.sv]
// Functional notes
// - gate_data2 follows input chosen by bits 6-4
// - gate_data1 follows input chosen by bits 2-0
// - bits 7 and 3 read zero, ignore writes
// - selector fields read/write, no defined reset value
// - reset leaves both selector fields unchanged
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module lcds_select_low
    import lcds_pkg::*;
(
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic                          hreadyout,
    output logic [31:0]                   hrdata,
    output logic                          hresp,
    input  wire logic [LCDS_N_INPUTS-1:0] cell_input,
    output lcds_gate_t                    gate_out
);

    lcds_bus_t bus_reg;
    lcds_bus_t bus_next;
    lcds_sel_t sel_reg;
    lcds_sel_t sel_next;
    logic      addr_take;
    logic      addr_hit;

    // zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = LCDS_HRESP_OKAY;
    assign hrdata    = bus_reg.rdata;

    // address phase accepted for this register
    assign addr_take = hsel && hready && (htrans == LCDS_HTRANS_NSEQ || htrans == LCDS_HTRANS_SEQ);
    assign addr_hit  = addr_take && (haddr == LCDS_SEL_OFFSET);

    // selector update in the write data phase; bits 7 and 3 have no storage
    always_comb begin
        sel_next = sel_reg;
        if (bus_reg.wr_pend) begin
            sel_next.d2 = hwdata[LCDS_D2_LSB +: LCDS_SEL_W];
            sel_next.d1 = hwdata[LCDS_D1_LSB +: LCDS_SEL_W];
        end
    end

    // bus state: pending write flag and registered read data
    always_comb begin
        bus_next         = bus_reg;
        bus_next.wr_pend = addr_hit && hwrite;
        if (addr_take && !hwrite) begin
            bus_next.rdata = LCDS_RDATA_RST;
            if (addr_hit) begin
                // read sees a write finishing in this same cycle
                bus_next.rdata[LCDS_D2_LSB +: LCDS_SEL_W] = sel_next.d2;
                bus_next.rdata[LCDS_D1_LSB +: LCDS_SEL_W] = sel_next.d1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_reg <= '{wr_pend: 1'b0, rdata: LCDS_RDATA_RST};
        end else begin
            bus_reg <= bus_next;
        end
    end

    // selector storage has no reset and keeps its value through one
    always_ff @(posedge hclk) begin
        sel_reg <= sel_next;
    end

    // combinational input multiplexers toward the gates
    always_comb begin
        gate_out.gate_data2 = cell_input[sel_reg.d2];
        gate_out.gate_data1 = cell_input[sel_reg.d1];
    end

    // checks below watch the bus and the selector from the inside; the
    // selector has no reset, so any check that needs a known code first
    // waits for a selector write, tracked by a helper flag that a bus
    // reset never clears
    logic       sel_written = 1'b0;
    // helper: codes of the last selector write, taken from the bus itself
    logic [2:0] gate_sel_d1_past;
    logic [2:0] gate_sel_d2_past;

    // shadow of the selector, fed from hwdata rather than from sel_reg
    always_ff @(posedge hclk) begin
        if (bus_reg.wr_pend) begin
            sel_written      <= 1'b1;
            gate_sel_d1_past <= hwdata[2:0];
            gate_sel_d2_past <= hwdata[6:4];
        end
    end

    // write data phase of the selector register
    sequence s_wr_dphase;
        bus_reg.wr_pend;
    endsequence

    // read address phase of the selector register
    sequence s_rd_addr;
        addr_hit && !hwrite;
    endsequence

    // read address phase of an unmapped address
    sequence s_rd_miss;
        addr_take && !addr_hit && !hwrite;
    endsequence

    // write address phase of an unmapped address
    sequence s_wr_miss;
        addr_take && !addr_hit && hwrite;
    endsequence

    // known selector and no write landing at the coming edge
    sequence s_quiet;
        sel_written && !bus_reg.wr_pend;
    endsequence

    // a new data2 code drives gate_data2 from the cycle after the
    // data phase, provided the inputs hold still meanwhile
    property p_data2_sel;
        @(posedge hclk) disable iff (!hresetn)
        s_wr_dphase ##1 $stable(cell_input) |-> gate_out.gate_data2 == cell_input[$past(hwdata[6:4])];
    endproperty
    a_data2_sel: assert property (p_data2_sel) else $error("data2 not from selected input");

    // a new data1 code drives gate_data1 from the cycle after the
    // data phase
    property p_data1_sel;
        @(posedge hclk) disable iff (!hresetn)
        s_wr_dphase |=> gate_out.gate_data1 == cell_input[$past(hwdata[2:0])];
    endproperty
    a_data1_sel: assert property (p_data1_sel) else $error("data1 not from selected input");

    // bits without storage and the upper word read as zero on every
    // read of the selector register
    property p_unimpl_zero;
        @(posedge hclk) disable iff (!hresetn)
        s_rd_addr |=> hrdata[7] == 1'b0 && hrdata[3] == 1'b0 && hrdata[31:8] == 24'h00_0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits read nonzero");

    // a read right behind a write sees the value being written,
    // in bits 6-0, with unstored bit 3 masked off
    property p_readback;
        @(posedge hclk) disable iff (!hresetn)
        bus_reg.wr_pend && addr_hit && !hwrite |=> hrdata[6:0] == ($past(hwdata[6:0]) & 7'h77);
    endproperty
    a_readback: assert property (p_readback) else $error("read does not return written value");

    // a later read returns the codes of the last write, however many
    // idle cycles or unmapped accesses lie between
    property p_readback_later;
        @(posedge hclk) disable iff (!hresetn)
        s_quiet ##0 s_rd_addr
            |=> hrdata[2:0] == gate_sel_d1_past && hrdata[6:4] == gate_sel_d2_past;
    endproperty
    a_readback_later: assert property (p_readback_later) else $error("selector lost between accesses");

    // a bus reset leaves the selector as it was two edges before
    // the edge at which the release is seen
    property p_keep_on_reset;
        @(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) && sel_written |-> sel_reg == $past(sel_reg, 2);
    endproperty
    a_keep_on_reset: assert property (p_keep_on_reset) else $error("selector changed by reset");

    // an input change reaches the gate lines in the same cycle, with
    // no clocked stage on the way
    property p_follow_input;
        @(posedge hclk) disable iff (!hresetn)
        s_quiet ##0 ($past(!bus_reg.wr_pend) && !$stable(cell_input))
            |-> gate_out.gate_data1 == cell_input[$past(sel_reg.d1)]
             && gate_out.gate_data2 == cell_input[$past(sel_reg.d2)];
    endproperty
    a_follow_input: assert property (p_follow_input) else $error("output lags its input");

    // the slave never stretches a data phase and always answers
    // with an OKAY response
    property p_zero_wait;
        @(posedge hclk) disable iff (!hresetn)
        addr_take |=> hreadyout && hresp == LCDS_HRESP_OKAY;
    endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("slave inserted wait or error");

    // a read of an unmapped address returns an all-zero word in its
    // data phase
    property p_miss_read_zero;
        @(posedge hclk) disable iff (!hresetn)
        s_rd_miss |=> hrdata == 32'h0000_0000;
    endproperty
    a_miss_read_zero: assert property (p_miss_read_zero) else $error("unmapped read not zero");

    // a write to an unmapped address never arms a selector update
    // for its data phase
    property p_miss_write_ignored;
        @(posedge hclk) disable iff (!hresetn)
        s_wr_miss |=> !bus_reg.wr_pend;
    endproperty
    a_miss_write_ignored: assert property (p_miss_write_ignored) else $error("unmapped write armed update");

    // without a write landing the selector keeps its codes, through
    // idle cycles and reads alike
    property p_sel_hold;
        @(posedge hclk) disable iff (!hresetn)
        s_quiet |=> $stable(sel_reg);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("selector changed without write");

    // read data stands until the next accepted read address phase
    // replaces it
    property p_rdata_hold;
        @(posedge hclk) disable iff (!hresetn)
        !(addr_take && !hwrite) |=> $stable(hrdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");

    // gate_data2 matches the input picked by the last written code
    // in the same cycle, compared against the bus shadow
    property p_gate2_now;
        @(posedge hclk) disable iff (!hresetn)
        s_quiet |-> gate_out.gate_data2 == cell_input[gate_sel_d2_past];
    endproperty
    a_gate2_now: assert property (p_gate2_now) else $error("data2 mux output wrong");

    // gate_data1 matches the input picked by the last written code
    // in the same cycle, compared against the bus shadow
    property p_gate1_now;
        @(posedge hclk) disable iff (!hresetn)
        s_quiet |-> gate_out.gate_data1 == cell_input[gate_sel_d1_past];
    endproperty
    a_gate1_now: assert property (p_gate1_now) else $error("data1 mux output wrong");

    // an accepted write address phase to the register opens its
    // data phase in the very next cycle
    property p_wr_take;
        @(posedge hclk) disable iff (!hresetn)
        addr_hit && hwrite |=> bus_reg.wr_pend;
    endproperty
    a_wr_take: assert property (p_wr_take) else $error("write address phase not taken");

    // a write data phase lasts one cycle unless another write to the
    // register was taken at the same edge
    property p_wr_pend_once;
        @(posedge hclk) disable iff (!hresetn)
        bus_reg.wr_pend && !(addr_hit && hwrite) |=> !bus_reg.wr_pend;
    endproperty
    a_wr_pend_once: assert property (p_wr_pend_once) else $error("write data phase stuck");

    // with no accepted address phase no data phase may follow, so
    // idle bus cycles never touch the selector
    property p_idle_no_write;
        @(posedge hclk) disable iff (!hresetn)
        !addr_take |=> !bus_reg.wr_pend;
    endproperty
    a_idle_no_write: assert property (p_idle_no_write) else $error("write armed on idle bus");

    // the edge that ends a write data phase stores both codes, and
    // nothing of the unstored bits
    property p_sel_after_write;
        @(posedge hclk) disable iff (!hresetn)
        s_wr_dphase
            |=> sel_reg.d1 == $past(hwdata[2:0]) && sel_reg.d2 == $past(hwdata[6:4]);
    endproperty
    a_sel_after_write: assert property (p_sel_after_write) else $error("selector not stored");

    // gate lines stand while neither the inputs nor the selector
    // change
    property p_gate_hold;
        @(posedge hclk) disable iff (!hresetn)
        s_quiet ##1 (!bus_reg.wr_pend && $stable(cell_input)) |-> $stable(gate_out);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("gate lines moved on their own");

    // a read of the register never arms a selector update, so reads
    // leave the codes alone
    property p_rd_no_write;
        @(posedge hclk) disable iff (!hresetn)
        s_rd_addr ##0 !bus_reg.wr_pend |=> !bus_reg.wr_pend;
    endproperty
    a_rd_no_write: assert property (p_rd_no_write) else $error("read armed a write");

    // read data comes out of a bus reset cleared, while the selector
    // itself is kept
    property p_rdata_reset;
        @(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> hrdata == LCDS_RDATA_RST;
    endproperty
    a_rdata_reset: assert property (p_rdata_reset) else $error("read data not cleared by reset");

endmodule
`default_nettype wire

// [include/lcds_pkg.sv]
package lcds_pkg;

    // register map
    localparam logic [31:0] LCDS_SEL_OFFSET  = 32'h0000_0000;

    // field layout of the selector register
    localparam int          LCDS_D1_LSB      = 0;
    localparam int          LCDS_D2_LSB      = 4;
    localparam int          LCDS_SEL_W       = 3;
    localparam int          LCDS_N_INPUTS    = 8;

    // reset values of the bus-side state
    localparam logic [31:0] LCDS_RDATA_RST   = 32'h0000_0000;

    // bus encodings
    localparam logic [1:0]  LCDS_HTRANS_NSEQ = 2'h2;
    localparam logic [1:0]  LCDS_HTRANS_SEQ  = 2'h3;
    localparam logic [2:0]  LCDS_HSIZE_WORD  = 3'h2;
    localparam logic        LCDS_HRESP_OKAY  = 1'h0;

    // selector storage, kept through every bus reset
    typedef struct packed {
        logic [LCDS_SEL_W-1:0] d2;
        logic [LCDS_SEL_W-1:0] d1;
    } lcds_sel_t;

    // bus-side state, cleared by reset
    typedef struct packed {
        logic        wr_pend;
        logic [31:0] rdata;
    } lcds_bus_t;

    // two selected data lines toward the gates
    typedef struct packed {
        logic gate_data2;
        logic gate_data1;
    } lcds_gate_t;

endpackage

// [test/lcds_select_low_test.sv]
`timescale 1ns/1ps
`default_nettype none
module lcds_select_low_test
    import lcds_pkg::*;
;
    logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0]       haddr, hwdata, hrdata, wd, rd, obs, exp_v;
    logic [1:0]        htrans;
    logic [2:0]        hsize, c1, c2;
    logic [7:0]        cell_input;
    lcds_gate_t        gate_out;
    logic [31:0]       exp_q[$];
    logic [31:0]       obs_q[$];
    int                failures = 0;
    int                samples_checked = 0;
    int                seed = 96379;
    event              seen;

    lcds_select_low lcds_select_low_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .cell_input(cell_input), .gate_out(gate_out));

    // 10 MHz clock
    always #50 hclk = ~hclk;

    task automatic give_verdict();
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // record an expectation and hand the observed value to the watcher
    task automatic note(input logic [31:0] e, input logic [31:0] got);
        exp_q.push_back(e);
        obs_q.push_back(got);
        -> seen;
    endtask

    // wait for hready at a rising edge, bounded
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            failures++;
            $display("BAD %0t bus hang", $time);
            give_verdict();
        end
    endtask

    // one single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= LCDS_HTRANS_NSEQ;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
        note({31'h0000_0000, LCDS_HRESP_OKAY}, {31'h0000_0000, hresp});
    endtask

    // new random inputs at an edge, outputs must follow in the same cycle
    task automatic check_gates();
        cell_input <= 8'($random(seed));
        #1;
        note({30'h0000_0000, cell_input[c2], cell_input[c1]}, {30'h0000_0000, gate_out});
        @(posedge hclk);
    endtask

    // compare each observed value with the oldest expectation; the queues
    // are drained so two notes in one time step are never lost
    always @(seen) begin
        while (exp_q.size() > 0 && obs_q.size() > 0) begin
            exp_v = exp_q.pop_front();
            obs = obs_q.pop_front();
            samples_checked++;
            if (obs !== exp_v) begin
                failures++;
                $display("BAD %0t got %h expected %h", $time, obs, exp_v);
            end
        end
    end

    // main sequence: eight code pairs (c2 = 7 - c1), unmapped access, reset in mid-run
    initial begin
        {hclk, hresetn, hsel, haddr, htrans, hwrite, hwdata, cell_input} = '0;
        hsize = LCDS_HSIZE_WORD;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            c1 = 3'(i);
            c2 = 3'h7 - 3'(i);
            wd = 32'($random(seed));
            wd[7:0] = {1'b1, c2, 1'b1, c1};
            bus(1'b1, LCDS_SEL_OFFSET, wd, rd);
            bus(1'b0, LCDS_SEL_OFFSET, 32'h0000_0000, rd);
            note({24'h00_0000, 1'b0, c2, 1'b0, c1}, rd);
            repeat (3) check_gates();
        end
        bus(1'b1, 32'h0000_0004, 32'h0000_0012, rd);
        bus(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
        note(32'h0000_0000, rd);
        bus(1'b0, LCDS_SEL_OFFSET, 32'h0000_0000, rd);
        note({24'h00_0000, 1'b0, c2, 1'b0, c1}, rd);
        hresetn <= 1'b0;
        repeat (2) check_gates();
        note(LCDS_RDATA_RST, hrdata);
        hresetn <= 1'b1;
        bus(1'b0, LCDS_SEL_OFFSET, 32'h0000_0000, rd);
        note({24'h00_0000, 1'b0, c2, 1'b0, c1}, rd);
        check_gates();
        give_verdict();
    end
endmodule
`default_nettype wire
